// >>> include/pdv_pkg.sv
// Constants shared by the precision divider comparator and its strobe divider.
// Assumes a single 10 MHz system clock with synchronous active-high reset.
package pdv_pkg;

  localparam int unsigned CLK_HZ      = 10_000_000;
  localparam int unsigned MASTER_HZ   = 1_024_000;
  localparam int unsigned FAST_HZ     = 2 * MASTER_HZ;
  // Fractional divider: add FAST_HZ/1000 per clock, wrap at CLK_HZ/1000
  localparam int unsigned ACC_W       = 14;
  localparam logic [13:0] ACC_MOD     = 14'(CLK_HZ / 1000);
  localparam logic [13:0] ACC_INC     = 14'(FAST_HZ / 1000);
  localparam logic [13:0] ACC_RST     = 14'h0000;

  localparam int unsigned CNT_W       = 13;
  localparam int unsigned LOW_W       = 12;
  localparam int unsigned WORD_W      = 25;
  localparam logic [12:0] CNT_FULL    = 13'h1FFF;
  localparam logic [12:0] CNT_RST     = 13'h0000;
  localparam logic [24:0] WORD_RST    = 25'h000_0000;
  // Busy while count bits 12..7 are all ones: last 128 steps of the scan
  localparam int unsigned BUSY_LSB    = 7;

  // Byte lanes of the demand word as selected by the host
  localparam logic [1:0]  SEL_B0      = 2'h0;
  localparam logic [1:0]  SEL_B1      = 2'h1;
  localparam logic [1:0]  SEL_B2      = 2'h2;
  localparam logic [1:0]  SEL_B3      = 2'h3;
  localparam int unsigned ECHO_W      = 5;

endpackage

// >>> include/pdv_tick_if.sv
// Strobes passed from the rate divider to the comparator core.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
interface pdv_tick_if;
  logic fast_phase_strobe;
  logic half_rate_phase_strobe;
  modport src (output fast_phase_strobe, output half_rate_phase_strobe);
  modport snk (input fast_phase_strobe, input half_rate_phase_strobe);
endinterface

// >>> rtl/pdv_strobe_gen.sv
// Rate divider: makes the 2.048 MHz and 1.024 MHz one-cycle enables.
// Assumes the 10 MHz clock; the strobes are evenly spread only on average.
`timescale 1ns/1ps
module pdv_strobe_gen (
  input  wire logic   clk,
  input  wire logic   srst,
  pdv_tick_if.src     tick
);

  typedef struct packed {
    logic [13:0] acc;
    logic        phase;
    logic        fast;
    logic        half;
  } pdv_gen_s;

  pdv_gen_s st_reg;
  pdv_gen_s st_next;

  always_comb begin
    logic [14:0] sum;
    sum = 15'(st_reg.acc) + 15'(pdv_pkg::ACC_INC);
    st_next      = st_reg;
    st_next.fast = 1'b0;
    st_next.half = 1'b0;
    if (sum >= 15'(pdv_pkg::ACC_MOD)) begin
      st_next.acc   = 14'(sum - 15'(pdv_pkg::ACC_MOD));
      st_next.fast  = 1'b1;
      st_next.phase = ~st_reg.phase;
      st_next.half  = st_reg.phase;
    end else begin
      st_next.acc = sum[13:0];
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      st_reg <= '{acc: pdv_pkg::ACC_RST, phase: 1'b0, fast: 1'b0, half: 1'b0};
    end else begin
      st_reg <= st_next;
    end
  end

  assign tick.fast_phase_strobe      = st_reg.fast;
  assign tick.half_rate_phase_strobe = st_reg.half;

endmodule

// >>> rtl/pdv_comparator.sv
// Dual comparator pulse-width generator for the precision reference divider.
// Assumes the host write port is on this clock; switch pulses go to isolators.
`timescale 1ns/1ps
module pdv_comparator (
  input  wire logic       CLK,
  input  wire logic       SRST,
  input  wire logic       WR_STROBE,
  input  wire logic [1:0] BYTE_SEL,
  input  wire logic [7:0] WR_DATA,
  output logic            BUSY,
  output logic [4:0]      DEMAND_ECHO,
  output logic            UPPER_SET_1,
  output logic            UPPER_SET_2,
  output logic            LOWER_SET,
  output logic            UPPER_RST_1,
  output logic            UPPER_RST_2,
  output logic            LOWER_MARK_END,
  output logic            LOAD_PULSE
);

  typedef struct packed {
    logic [24:0] buffer;
    logic [12:0] count;
    logic [12:0] upper_wk;
    logic [11:0] lower_wk;
    logic        upper_pend;
    logic        lower_pend;
    logic        busy;
    logic        set_p;
    logic        upper_rst_p;
    logic        lower_rst_p;
    logic        load_p;
  } pdv_core_s;

  pdv_core_s  st_reg;
  pdv_core_s  st_next;
  pdv_tick_if tick ();

  pdv_strobe_gen u_strobe (
    .clk  (CLK),
    .srst (SRST),
    .tick (tick)
  );

  // Lower path compares the top twelve counter bits on even steps only
  function automatic logic lower_hit(input logic [12:0] cnt, input logic [11:0] word);
    lower_hit = (cnt[12:1] == word) && !cnt[0];
  endfunction

  always_comb begin
    logic [12:0] cnt_n;
    logic        full;
    cnt_n = st_reg.count;
    full  = 1'b0;
    st_next             = st_reg;
    st_next.set_p       = 1'b0;
    st_next.upper_rst_p = 1'b0;
    st_next.lower_rst_p = 1'b0;
    st_next.load_p      = 1'b0;

    if (WR_STROBE) begin
      case (BYTE_SEL)
        pdv_pkg::SEL_B0: st_next.buffer[7:0]   = WR_DATA;
        pdv_pkg::SEL_B1: st_next.buffer[15:8]  = WR_DATA;
        pdv_pkg::SEL_B2: st_next.buffer[23:16] = WR_DATA;
        pdv_pkg::SEL_B3: st_next.buffer[24]    = WR_DATA[0];
        default:         st_next.buffer        = st_reg.buffer;
      endcase
    end

    // Clears come before the arming below, so a fresh match in the same cycle wins.
    // At the wrap no lower end from the old word is still pending; it cleared one step after its match.
    // upper reset on next fast strobe after the match
    if (st_reg.upper_pend && tick.fast_phase_strobe) begin
      st_next.upper_pend  = 1'b0;
      st_next.upper_rst_p = 1'b1;
    end
    // lower reset on next half-rate strobe after the match
    if (st_reg.lower_pend && tick.half_rate_phase_strobe) begin
      st_next.lower_pend  = 1'b0;
      st_next.lower_rst_p = 1'b1;
    end

    // single counter stepping at the master rate
    if (tick.half_rate_phase_strobe) begin
      full  = (st_reg.count == pdv_pkg::CNT_FULL);
      // natural wrap to zero, no pause
      cnt_n = 13'(st_reg.count + 13'h0001);
      st_next.count = cnt_n;
      if (full) begin
        st_next.upper_wk = st_next.buffer[24:12];
        st_next.lower_wk = st_next.buffer[11:0];
        st_next.load_p   = 1'b1;
        // set pulses open the mark phase
        st_next.set_p    = 1'b1;
      end
      if (cnt_n == st_next.upper_wk) begin
        st_next.upper_pend = 1'b1;
      end
      if (lower_hit(cnt_n, st_next.lower_wk)) begin
        st_next.lower_pend = 1'b1;
      end
    end

    // busy over the last 128 steps of the scan
    st_next.busy = &st_next.count[pdv_pkg::CNT_W-1:pdv_pkg::BUSY_LSB];
  end

  always_ff @(posedge CLK) begin
    if (SRST) begin
      st_reg <= '{buffer: pdv_pkg::WORD_RST, count: pdv_pkg::CNT_RST,
                  upper_wk: pdv_pkg::CNT_RST, lower_wk: 12'h000,
                  default: 1'b0};
    end else begin
      st_reg <= st_next;
    end
  end

  assign BUSY           = st_reg.busy;
  assign DEMAND_ECHO    = st_reg.buffer[24:20];
  assign UPPER_SET_1    = st_reg.set_p;
  assign UPPER_SET_2    = st_reg.set_p;
  assign LOWER_SET      = st_reg.set_p;
  assign UPPER_RST_1    = st_reg.upper_rst_p;
  assign UPPER_RST_2    = st_reg.upper_rst_p;
  assign LOWER_MARK_END = st_reg.lower_rst_p;
  assign LOAD_PULSE     = st_reg.load_p;

endmodule

// >>> dv/pdv_comparator_properties.sv
// Checker for the comparator's switch pulses and host echo.
// Assumes it is bound to pdv_comparator and sees only its ports.
`timescale 1ns/1ps
module pdv_comparator_properties (
  input wire logic       CLK,
  input wire logic       SRST,
  input wire logic       WR_STROBE,
  input wire logic [1:0] BYTE_SEL,
  input wire logic [7:0] WR_DATA,
  input wire logic       BUSY,
  input wire logic [4:0] DEMAND_ECHO,
  input wire logic       UPPER_SET_1,
  input wire logic       UPPER_SET_2,
  input wire logic       LOWER_SET,
  input wire logic       UPPER_RST_1,
  input wire logic       UPPER_RST_2,
  input wire logic       LOWER_MARK_END,
  input wire logic       LOAD_PULSE
);
  default clocking @(posedge CLK); endclocking
  default disable iff (SRST);
  property p_set_trio; (UPPER_SET_1 || LOWER_SET) |-> UPPER_SET_2 && UPPER_SET_1 == LOWER_SET; endproperty
  a_set_trio: assert property (p_set_trio) else $error("set pulses differ");
  property p_load_set; LOAD_PULSE == UPPER_SET_1; endproperty
  a_load_set: assert property (p_load_set) else $error("load not with set");
  property p_set_once; UPPER_SET_1 |=> !UPPER_SET_1 [*8]; endproperty
  a_set_once: assert property (p_set_once) else $error("set repeats");
  property p_busy_end; LOAD_PULSE |-> $past(BUSY) && !BUSY; endproperty
  a_busy_end: assert property (p_busy_end) else $error("busy not ending at load");
  property p_busy_len; $rose(BUSY) |-> BUSY [*8]; endproperty
  a_busy_len: assert property (p_busy_len) else $error("busy too short");
  property p_rst_pair; UPPER_RST_1 |-> UPPER_RST_2 && !UPPER_SET_1; endproperty
  a_rst_pair: assert property (p_rst_pair) else $error("upper resets apart");
  property p_echo; WR_STROBE && BYTE_SEL == 2'h3 |=> DEMAND_ECHO[4] == $past(WR_DATA[0]); endproperty
  a_echo: assert property (p_echo) else $error("echo wrong");
  property p_low_once; LOWER_MARK_END |=> !LOWER_MARK_END [*8]; endproperty
  a_low_once: assert property (p_low_once) else $error("lower end repeats");
endmodule
bind pdv_comparator pdv_comparator_properties i_props (.CLK, .SRST, .WR_STROBE, .BYTE_SEL,
  .WR_DATA, .BUSY, .DEMAND_ECHO, .UPPER_SET_1, .UPPER_SET_2, .LOWER_SET, .UPPER_RST_1,
  .UPPER_RST_2, .LOWER_MARK_END, .LOAD_PULSE);

// >>> dv/pdv_host_model.sv
// Host model: sends one 25-bit demand word as four byte writes.
// Assumes the design clock; a GO pulse starts a word, only while BUSY is low.
`timescale 1ns/1ps
module pdv_host_model (
  input  wire logic        CLK,
  input  wire logic        BUSY,
  input  wire logic        GO,
  input  wire logic [24:0] WORD,
  output logic             WR_STROBE,
  output logic [1:0]       BYTE_SEL,
  output logic [7:0]       WR_DATA,
  output logic             DONE
);
  int lane = 5;
  initial begin
    WR_STROBE = 1'b0;
    BYTE_SEL  = 2'h0;
    WR_DATA   = 8'h00;
    DONE      = 1'b0;
  end
  always @(posedge CLK) begin
    if (!GO && lane < 4) begin
      WR_STROBE <= 1'b1;
      BYTE_SEL  <= 2'(lane);
      WR_DATA   <= 8'(WORD >> (8 * lane));
      DONE      <= (lane == 3);
    end else begin
      WR_STROBE <= 1'b0;
      DONE      <= 1'b0;
      // Stale data would look valid, so idle bytes toggle
      WR_DATA   <= ~WR_DATA;
    end
    if (GO) lane <= 4;
    else if (lane == 4 && !BUSY) lane <= 0;
    else if (lane < 4) lane <= lane + 1;
  end
endmodule

// >>> dv/tb_top.sv
// Testbench: demand words, echo, then load and mark timing of one scan.
// Assumes a 10 MHz clock; one full scan takes about 80000 cycles.
`timescale 1ns/1ps
module tb_top;
  logic CLK = 0, SRST = 1, GO = 0, DONE, WR_STROBE, BUSY, LOAD_PULSE;
  logic UPPER_SET_1, UPPER_SET_2, LOWER_SET, UPPER_RST_1, UPPER_RST_2, LOWER_MARK_END;
  logic [24:0] WORD = 0;
  logic [1:0]  BYTE_SEL;
  logic [7:0]  WR_DATA;
  logic [4:0]  DEMAND_ECHO;
  int n_errors = 0, total_checks = 0, cyc = 0, seed = 32'h9d04, w = 0, exp_q[$];
  realtime t_ld = 0, t_up = 0, t_lo = 0, d_up = 0, d_lo = 0;
  initial forever #50 CLK = ~CLK;
  pdv_comparator i_dut (.CLK, .SRST, .WR_STROBE, .BYTE_SEL, .WR_DATA, .BUSY, .DEMAND_ECHO,
    .UPPER_SET_1, .UPPER_SET_2, .LOWER_SET, .UPPER_RST_1, .UPPER_RST_2, .LOWER_MARK_END,
    .LOAD_PULSE);
  pdv_host_model i_host (.CLK, .BUSY, .GO, .WORD, .WR_STROBE, .BYTE_SEL, .WR_DATA, .DONE);
  task check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task tally_and_finish;
    if (n_errors == 0 && total_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  always @(posedge CLK) begin
    cyc <= cyc + 1;
    if (t_ld == 0 && (UPPER_RST_1 || LOWER_MARK_END)) check(1, 0);
  end
  always @(posedge CLK) if (cyc == 95000) begin
    n_errors++;
    tally_and_finish();
  end
  initial begin
    repeat (12) @(posedge CLK);
    SRST <= 0;
    for (int i = 0; i < 2; i++) begin
      @(posedge CLK);
      // Second word keeps both delays short so the run ends soon after the load
      WORD <= (i == 0) ? 25'($random(seed)) :
              {13'(($random(seed) & 63) + 8), 12'(($random(seed) & 63) + 4)};
      GO   <= 1;
      @(posedge CLK) GO <= 0;
      @(posedge CLK iff DONE);
      @(posedge CLK);
      exp_q.push_back(WORD);
      check(DEMAND_ECHO, WORD[24:20]);
    end
    @(posedge CLK iff LOAD_PULSE);
    t_ld = $realtime;
    check({UPPER_SET_1, UPPER_SET_2, LOWER_SET, BUSY}, 4'he);
    while (t_up == 0 || t_lo == 0) begin
      @(posedge CLK);
      if (UPPER_RST_1 && t_up == 0) t_up = $realtime;
      if (LOWER_MARK_END && t_lo == 0) t_lo = $realtime;
    end
    w = exp_q[$];
    d_up = t_up - t_ld - ((w >> 12) & 8191) * 976.5625;
    d_lo = t_lo - t_ld - (w & 4095) * 1953.125;
    check((d_up >= -300.0) && (d_up <= 1700.0), 1);
    check((d_lo >= -300.0) && (d_lo <= 1700.0), 1);
    tally_and_finish();
  end
endmodule
